// File: pkg/iic_consts.vh
// Constants for the isolated input channel alarm logic.
// Assumes a 125 MHz clock and analog samples in 10 uV or 10 nA units.
`ifndef IIC_CONSTS_VH
`define IIC_CONSTS_VH

// Clock rate and time base
`define IIC_CLK_HZ       125000000
`define IIC_MS_PER_S     1000
`define IIC_MS_CYCLES    (`IIC_CLK_HZ / `IIC_MS_PER_S)

// Global register word addresses
`define IIC_A_CTRL       8'h00
`define IIC_A_RTS        8'h01
`define IIC_A_RPI        8'h02
`define IIC_A_IRQ_STAT   8'h03
`define IIC_A_IRQ_MASK   8'h04
`define IIC_A_STATUS     8'h05

// Per-channel window: address[6:4] = channel + 1, address[3:0] = field
`define IIC_S_CFG        4'h0
`define IIC_S_TA         4'h1
`define IIC_S_HH         4'h2
`define IIC_S_H          4'h3
`define IIC_S_L          4'h4
`define IIC_S_LL         4'h5
`define IIC_S_DB         4'h6
`define IIC_S_RATE       4'h7
`define IIC_S_DATA       4'h8
`define IIC_S_CHSTAT     4'h9

// Control bits
`define IIC_CTRL_RUN     0
`define IIC_CTRL_FLOAT   1

// Channel config fields
`define IIC_CFG_RANGE_LO 0
`define IIC_CFG_DIS      2
`define IIC_CFG_LATCH_LO 3

// Range codes
`define IIC_RNG_BI10     2'h0
`define IIC_RNG_UNI10    2'h1
`define IIC_RNG_UNI5     2'h2
`define IIC_RNG_MA20     2'h3

// Range bounds, 10 uV or 10 nA units
`define IIC_V10_HI       32'sh001017E0
`define IIC_V10_LO       (-32'sh001017E0)
`define IIC_V5_HI        32'sh00080BF0
`define IIC_MA20_HI      32'sh00202FC0
`define IIC_ZERO_LO      32'sh00000000

// Integer mode forced codes
`define IIC_INT_MAX      32'sh00007FFF
`define IIC_INT_MIN      (-32'sh00008000)

// Channel status bits
`define IIC_ST_HH        0
`define IIC_ST_H         1
`define IIC_ST_L         2
`define IIC_ST_LL        3
`define IIC_ST_RATE      4
`define IIC_ST_OVER      5
`define IIC_ST_UNDER     6

// Interrupt status bits
`define IIC_IRQ_SCAN     0
`define IIC_IRQ_LIMIT    1
`define IIC_IRQ_ALARM    2

// Reset values and filter fraction width
`define IIC_RST_CTRL     8'h03
`define IIC_RST_RTS      16'h0019
`define IIC_RST_RPI      16'h0019
`define IIC_RST_CFG      8'h00
`define IIC_FRAC_BITS    16

`endif

// File: rtl/iic_alarm_logic.v
// Six-channel input scan, limit, filter, process and rate alarm logic.
// Assumes converter words on adc_data are current whenever a scan gathers them.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`default_nettype none
`include "iic_consts.vh"

module iic_alarm_logic #(
    parameter NCH         = 6,
    parameter MS_CYCLES   = `IIC_MS_CYCLES,
    parameter INT_SHIFT   = 5,
    parameter MULTI_RANGE = 1
) (
    // Clock, reset, enable
    input  wire               clock,
    input  wire               rst_n,
    input  wire               ce,
    // Register port
    input  wire [7:0]         addr,
    input  wire [31:0]        wr_data,
    input  wire               wr_en,
    input  wire               rd_en,
    output reg  [31:0]        rd_data,
    // Converter words, one 32-bit signed word per channel
    input  wire [NCH*32-1:0]  adc_data,
    // Field detection pins
    input  wire [NCH-1:0]     wire_off_pin,
    input  wire               removable_terminal_block_off_pin,
    // Multicast stream
    output reg                mc_valid,
    output reg  [2:0]         mc_chan,
    output reg  [31:0]        mc_data,
    output reg  [6:0]         mc_status,
    output reg                mc_last,
    output reg                mc_from_scan,
    // Interrupt
    output wire               irq
);
    localparam S_IDLE = 2'h0;
    localparam S_DIV  = 2'h1;
    localparam S_CALC = 2'h2;
    localparam S_SEND = 2'h3;

    function signed [31:0] bound_hi;
        input [1:0] rng;
        begin
            case (rng)
                `IIC_RNG_UNI5: bound_hi = `IIC_V5_HI;
                `IIC_RNG_MA20: bound_hi = `IIC_MA20_HI;
                default:       bound_hi = `IIC_V10_HI;
            endcase
        end
    endfunction

    function signed [31:0] bound_lo;
        input [1:0] rng;
        begin
            bound_lo = (rng == `IIC_RNG_BI10) ? `IIC_V10_LO : `IIC_ZERO_LO;
        end
    endfunction

    function signed [31:0] sat16;
        input signed [31:0] v;
        begin
            if (v > `IIC_INT_MAX)
                sat16 = `IIC_INT_MAX;
            else if (v < `IIC_INT_MIN)
                sat16 = `IIC_INT_MIN;
            else
                sat16 = v;
        end
    endfunction

    // Configuration and channel state
    reg        [7:0]  ctrl_reg;
    reg        [15:0] rts_reg;
    reg        [15:0] rpi_reg;
    reg        [2:0]  irq_stat_reg;
    reg        [2:0]  irq_mask_reg;
    reg        [7:0]  cfg_mem   [0:NCH-1];
    reg        [15:0] ta_mem    [0:NCH-1];
    reg signed [31:0] hh_mem    [0:NCH-1];
    reg signed [31:0] h_mem     [0:NCH-1];
    reg signed [31:0] l_mem     [0:NCH-1];
    reg signed [31:0] ll_mem    [0:NCH-1];
    reg signed [31:0] db_mem    [0:NCH-1];
    reg        [31:0] rate_mem  [0:NCH-1];
    reg signed [31:0] y_mem     [0:NCH-1];
    reg signed [31:0] xprev_mem [0:NCH-1];
    reg        [31:0] out_mem   [0:NCH-1];
    reg        [6:0]  st_mem    [0:NCH-1];

    // Pin synchronisers, three stages
    reg [NCH:0] pin_s1_reg;
    reg [NCH:0] pin_s2_reg;
    reg [NCH:0] pin_s3_reg;
    reg [NCH:0] pin_q_reg;

    // Timers and sequencer
    reg [31:0]        ms_cnt_reg;
    reg [15:0]        rts_cnt_reg;
    reg [15:0]        rpi_cnt_reg;
    reg               rpi_pend_reg;
    reg [1:0]         state_reg;
    reg [2:0]         ch_reg;
    reg [NCH*32-1:0]  snap_reg;
    reg               div_start_reg;
    wire              div_done;
    wire [31:0]       div_quot;

    wire float_mode = ctrl_reg[`IIC_CTRL_FLOAT];
    wire running    = ctrl_reg[`IIC_CTRL_RUN];
    wire ms_tick    = (ms_cnt_reg == MS_CYCLES - 1);
    wire rts_due    = running && ms_tick && (rts_reg != 16'h0000) && (rts_cnt_reg + 16'h0001 >= rts_reg);
    wire rpi_due    = running && ms_tick && (rpi_reg != 16'h0000) && (rpi_cnt_reg + 16'h0001 >= rpi_reg);

    iic_lag_div #(.W(32)) u_div (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .start (div_start_reg),
        .numer ({rts_reg, 16'h0000}),
        .denom ({15'h0000, {1'b0, rts_reg} + {1'b0, ta_mem[ch_reg]}}),
        .busy  (),
        .done  (div_done),
        .quot  (div_quot)
    );

    // Per-channel evaluation of the channel under ch_reg
    reg signed [31:0] x;
    reg signed [31:0] yp;
    reg signed [32:0] dlt;
    reg signed [50:0] prod;
    reg signed [31:0] y;
    reg signed [31:0] hi;
    reg signed [31:0] lo;
    reg        [1:0]  rng;
    reg               dis;
    reg               cur;
    reg               fmax;
    reg               fmin;
    reg        [3:0]  latch;
    reg        [6:0]  st_old;
    reg        [6:0]  st_new;
    reg        [31:0] dout;
    reg signed [32:0] rdiff;
    reg        [47:0] rlhs;
    reg        [47:0] rrhs;
    always @* begin
        x      = snap_reg[ch_reg*32 +: 32];
        yp     = y_mem[ch_reg];
        rng    = cfg_mem[ch_reg][`IIC_CFG_RANGE_LO +: 2];
        dis    = cfg_mem[ch_reg][`IIC_CFG_DIS];
        latch  = cfg_mem[ch_reg][`IIC_CFG_LATCH_LO +: 4];
        st_old = st_mem[ch_reg];
        hi     = bound_hi(rng);
        lo     = bound_lo(rng);
        cur    = (rng == `IIC_RNG_MA20);
        // On a 20 mA range channel, terminal block removal outranks an open wire
        fmax   = (pin_q_reg[ch_reg] & ~cur) | (pin_q_reg[NCH] & cur & (MULTI_RANGE != 0));
        fmin   = pin_q_reg[ch_reg] & cur & ~fmax;
        dlt    = {x[31], x} - {yp[31], yp};
        prod   = $signed({1'b0, div_quot[16:0]}) * dlt;
        if (float_mode && ta_mem[ch_reg] != 16'h0000)
            y = yp + prod[47:16];
        else
            y = x;
        if (float_mode)
            dout = fmax ? hi : (fmin ? lo : y);
        else
            dout = fmax ? `IIC_INT_MAX : (fmin ? `IIC_INT_MIN : sat16(x >>> INT_SHIFT));
        st_new = 7'h00;
        // Over and under flags are recomputed every sample, so an in-range sample clears them
        st_new[`IIC_ST_OVER]  = ~dis & (fmax | (~fmin & (x > hi)));
        st_new[`IIC_ST_UNDER] = ~dis & (fmin | (~fmax & (x < lo)));
        if (float_mode && !dis) begin
            st_new[`IIC_ST_HH] = (y > hh_mem[ch_reg]) | (st_old[`IIC_ST_HH] & (latch[0] | (y > hh_mem[ch_reg] - db_mem[ch_reg])));
            st_new[`IIC_ST_H]  = (y > h_mem[ch_reg])  | (st_old[`IIC_ST_H]  & (latch[1] | (y > h_mem[ch_reg] - db_mem[ch_reg])));
            st_new[`IIC_ST_L]  = (y < l_mem[ch_reg])  | (st_old[`IIC_ST_L]  & (latch[2] | (y < l_mem[ch_reg] + db_mem[ch_reg])));
            st_new[`IIC_ST_LL] = (y < ll_mem[ch_reg]) | (st_old[`IIC_ST_LL] & (latch[3] | (y < ll_mem[ch_reg] + db_mem[ch_reg])));
        end
        // Compare |delta| * 1000 against trigger * interval in ms to avoid a divide
        rdiff = {x[31], x} - {xprev_mem[ch_reg][31], xprev_mem[ch_reg]};
        if (rdiff[32])
            rdiff = -rdiff;
        rlhs = {15'h0000, rdiff[32:0]} * 48'h0000000003E8;
        rrhs = {16'h0000, rate_mem[ch_reg]} * {32'h00000000, rts_reg};
        st_new[`IIC_ST_RATE] = float_mode & ~dis & (rlhs > rrhs);
    end

    // Sequencer, timers and channel results
    integer i;
    integer j;
    always @(posedge clock) begin
        if (!rst_n) begin
            ms_cnt_reg    <= 32'h00000000;
            rts_cnt_reg   <= 16'h0000;
            rpi_cnt_reg   <= 16'h0000;
            rpi_pend_reg  <= 1'b0;
            state_reg     <= S_IDLE;
            ch_reg        <= 3'h0;
            snap_reg      <= {NCH*32{1'b0}};
            div_start_reg <= 1'b0;
            mc_valid      <= 1'b0;
            mc_chan       <= 3'h0;
            mc_data       <= 32'h00000000;
            mc_status     <= 7'h00;
            mc_last       <= 1'b0;
            mc_from_scan  <= 1'b0;
            pin_s1_reg    <= {NCH+1{1'b0}};
            pin_s2_reg    <= {NCH+1{1'b0}};
            pin_s3_reg    <= {NCH+1{1'b0}};
            pin_q_reg     <= {NCH+1{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                y_mem[i]     <= 32'sh00000000;
                xprev_mem[i] <= 32'sh00000000;
                out_mem[i]   <= 32'h00000000;
                st_mem[i]    <= 7'h00;
            end
        end else if (ce) begin
            pin_s1_reg <= {removable_terminal_block_off_pin, wire_off_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            // A change is taken only where the last two stages agree
            pin_q_reg  <= (pin_s2_reg & pin_s3_reg) | (pin_q_reg & (pin_s2_reg | pin_s3_reg));
            ms_cnt_reg <= ms_tick ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
            if (ms_tick) begin
                rts_cnt_reg <= rts_due ? 16'h0000 : rts_cnt_reg + 16'h0001;
                rpi_cnt_reg <= rpi_due ? 16'h0000 : rpi_cnt_reg + 16'h0001;
            end
            div_start_reg <= 1'b0;
            mc_valid      <= 1'b0;
            mc_last       <= 1'b0;
            if (rpi_due)
                rpi_pend_reg <= 1'b1;
            // Software clear of latched status; a same-cycle result below wins
            if (wr_en && !addr[7] && addr[3:0] == `IIC_S_CHSTAT && addr[6:4] >= 3'h1 && addr[6:4] <= NCH)
                st_mem[addr[6:4] - 3'h1] <= st_mem[addr[6:4] - 3'h1] & ~wr_data[6:0];
            case (state_reg)
                S_IDLE: begin
                    if (rts_due) begin
                        snap_reg      <= adc_data;
                        ch_reg        <= 3'h0;
                        div_start_reg <= 1'b1;
                        state_reg     <= S_DIV;
                    end else if (rpi_pend_reg || rpi_due) begin
                        rpi_pend_reg  <= 1'b0;
                        mc_from_scan  <= 1'b0;
                        ch_reg        <= 3'h0;
                        state_reg     <= S_SEND;
                    end
                end
                S_DIV: begin
                    if (div_done)
                        state_reg <= S_CALC;
                end
                S_CALC: begin
                    y_mem[ch_reg]     <= y;
                    xprev_mem[ch_reg] <= x;
                    out_mem[ch_reg]   <= dout;
                    st_mem[ch_reg]    <= st_new;
                    if (ch_reg == NCH - 1) begin
                        ch_reg       <= 3'h0;
                        mc_from_scan <= 1'b1;
                        state_reg    <= S_SEND;
                    end else begin
                        ch_reg        <= ch_reg + 3'h1;
                        div_start_reg <= 1'b1;
                        state_reg     <= S_DIV;
                    end
                end
                S_SEND: begin
                    mc_valid  <= 1'b1;
                    mc_chan   <= ch_reg;
                    mc_data   <= out_mem[ch_reg];
                    mc_status <= st_mem[ch_reg];
                    mc_last   <= (ch_reg == NCH - 1);
                    if (ch_reg == NCH - 1) begin
                        ch_reg    <= 3'h0;
                        state_reg <= S_IDLE;
                    end else begin
                        ch_reg <= ch_reg + 3'h1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Register writes and interrupt status
    wire       ch_win = !addr[7] && addr[6:4] >= 3'h1 && addr[6:4] <= NCH;
    wire [2:0] wch    = addr[6:4] - 3'h1;
    wire       calc   = (state_reg == S_CALC);
    wire [2:0] ev     = {calc & (|(st_new[4:0] & ~st_old[4:0])),
                         calc & (|(st_new[6:5] & ~st_old[6:5])),
                         calc & (ch_reg == NCH - 1)};
    assign irq = |(irq_stat_reg & irq_mask_reg);

    always @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg     <= `IIC_RST_CTRL;
            rts_reg      <= `IIC_RST_RTS;
            rpi_reg      <= `IIC_RST_RPI;
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
            for (j = 0; j < NCH; j = j + 1) begin
                cfg_mem[j]  <= `IIC_RST_CFG;
                ta_mem[j]   <= 16'h0000;
                hh_mem[j]   <= 32'sh7FFFFFFF;
                h_mem[j]    <= 32'sh7FFFFFFF;
                l_mem[j]    <= 32'sh80000000;
                ll_mem[j]   <= 32'sh80000000;
                db_mem[j]   <= 32'sh00000000;
                rate_mem[j] <= 32'hFFFFFFFF;
            end
        end else if (ce) begin
            // Set wins over a write-one clear in the same cycle
            irq_stat_reg <= (irq_stat_reg & ~((wr_en && addr == `IIC_A_IRQ_STAT) ? wr_data[2:0] : 3'h0)) | ev;
            if (wr_en) begin
                case (addr)
                    `IIC_A_CTRL:     ctrl_reg     <= wr_data[7:0];
                    `IIC_A_RTS:      rts_reg      <= wr_data[15:0];
                    `IIC_A_RPI:      rpi_reg      <= wr_data[15:0];
                    `IIC_A_IRQ_MASK: irq_mask_reg <= wr_data[2:0];
                    default: begin
                        if (ch_win) begin
                            case (addr[3:0])
                                `IIC_S_CFG:  cfg_mem[wch]  <= wr_data[7:0];
                                `IIC_S_TA:   ta_mem[wch]   <= wr_data[15:0];
                                `IIC_S_HH:   hh_mem[wch]   <= wr_data;
                                `IIC_S_H:    h_mem[wch]    <= wr_data;
                                `IIC_S_L:    l_mem[wch]    <= wr_data;
                                `IIC_S_LL:   ll_mem[wch]   <= wr_data;
                                `IIC_S_DB:   db_mem[wch]   <= wr_data;
                                `IIC_S_RATE: rate_mem[wch] <= wr_data;
                                default:     ;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= 32'h00000000;
        end else if (ce) begin
            rd_data <= 32'h00000000;
            if (rd_en) begin
                case (addr)
                    `IIC_A_CTRL:     rd_data <= {24'h000000, ctrl_reg};
                    `IIC_A_RTS:      rd_data <= {16'h0000, rts_reg};
                    `IIC_A_RPI:      rd_data <= {16'h0000, rpi_reg};
                    `IIC_A_IRQ_STAT: rd_data <= {29'h00000000, irq_stat_reg};
                    `IIC_A_IRQ_MASK: rd_data <= {29'h00000000, irq_mask_reg};
                    `IIC_A_STATUS:   rd_data <= {21'h000000, pin_q_reg, rpi_pend_reg, state_reg, irq};
                    default: begin
                        if (ch_win) begin
                            case (addr[3:0])
                                `IIC_S_CFG:    rd_data <= {24'h000000, cfg_mem[wch]};
                                `IIC_S_TA:     rd_data <= {16'h0000, ta_mem[wch]};
                                `IIC_S_HH:     rd_data <= hh_mem[wch];
                                `IIC_S_H:      rd_data <= h_mem[wch];
                                `IIC_S_L:      rd_data <= l_mem[wch];
                                `IIC_S_LL:     rd_data <= ll_mem[wch];
                                `IIC_S_DB:     rd_data <= db_mem[wch];
                                `IIC_S_RATE:   rd_data <= rate_mem[wch];
                                `IIC_S_DATA:   rd_data <= out_mem[wch];
                                `IIC_S_CHSTAT: rd_data <= {25'h0000000, st_mem[wch]};
                                default:       rd_data <= 32'h00000000;
                            endcase
                        end
                    end
                endcase
            end
        end
    end
endmodule // iic_alarm_logic

`default_nettype wire

// File: rtl/iic_lag_div.v
// Restoring unsigned divider for the lag filter coefficient.
// Assumes start is a one-cycle pulse and the divisor is nonzero.
`default_nettype none

module iic_lag_div #(
    parameter W = 32
) (
    // Clock and reset
    input  wire         clock,
    input  wire         rst_n,
    input  wire         ce,
    // Operands
    input  wire         start,
    input  wire [W-1:0] numer,
    input  wire [W-1:0] denom,
    // Result
    output reg          busy,
    output reg          done,
    output reg  [W-1:0] quot
);
    reg  [W-1:0] rem_reg;
    reg  [7:0]   cnt_reg;
    wire [W:0]   shifted = {rem_reg, quot[W-1]};
    wire [W:0]   trial   = shifted - {1'b0, denom};

    always @(posedge clock) begin
        if (!rst_n) begin
            rem_reg <= {W{1'b0}};
            quot    <= {W{1'b0}};
            cnt_reg <= 8'h00;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                rem_reg <= {W{1'b0}};
                quot    <= numer;
                cnt_reg <= W[7:0];
                busy    <= 1'b1;
            end else if (busy) begin
                if (trial[W]) begin
                    rem_reg <= shifted[W-1:0];
                    quot    <= {quot[W-2:0], 1'b0};
                end else begin
                    rem_reg <= trial[W-1:0];
                    quot    <= {quot[W-2:0], 1'b1};
                end
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // iic_lag_div

`default_nettype wire

// File: test/iic_alarm_logic_tb_top.sv
// Bench: registers, random limit cases, wire off, resend and interrupt.
// Assumes the checker binds itself; ce is held high.
`default_nettype none
`include "iic_consts.vh"
module iic_alarm_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clock = 0, rst_n = 0, wr_en = 0, rd_en = 0, removable_terminal_block = 0, mc_valid, mc_last, mc_from_scan, irq;
    logic [7:0]   addr = 0;
    logic [31:0]  wr_data = 0, rd_data, mc_data;
    logic [191:0] adc = 0;
    logic [5:0]   wo = 0;
    logic [2:0]   mc_chan;
    logic [6:0]   mc_status;
    logic [1:0]   rg [6];
    logic         dis [6];
    int           bad_count = 0, check_count = 0, k, n, fl;
    always #4 clock = ~clock;
    iic_alarm_logic #(.MS_CYCLES(20)) i_dut (.clock, .rst_n, .ce(1'b1), .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .adc_data(adc), .wire_off_pin(wo), .removable_terminal_block_off_pin(removable_terminal_block), .mc_valid,
        .mc_chan, .mc_data, .mc_status, .mc_last, .mc_from_scan, .irq);
    iic_owner_model i_own (.clock, .mc_valid, .mc_chan, .mc_data, .mc_status, .mc_last, .mc_from_scan);
    task summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (e !== g) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1;
        @(posedge clock);
        wr_en <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1;
        @(posedge clock);
        rd_en <= 0;
        #1 chk("rd_data", e, rd_data);
    endtask
    // Bounded wait for m more complete multicast sets
    task sets(input int m);
        n = i_own.cnt + m;
        for (k = 0; k < 3000 && i_own.cnt < n; k++)
            @(posedge clock);
        if (i_own.cnt < n) begin
            bad_count++;
            summarize();
        end
    endtask
    // Change channel 0 just after a set lands, so the next set is the first to see it
    task step(input logic [31:0] v, input logic [6:0] e);
        sets(1);
        adc[31:0] <= v;
        sets(1);
        chk("ch0_status", {25'h0, e}, i_own.stat[0]);
    endtask
    function logic signed [31:0] hi(input logic [1:0] r);
        return r == `IIC_RNG_MA20 ? `IIC_MA20_HI : r == `IIC_RNG_UNI5 ? `IIC_V5_HI : `IIC_V10_HI;
    endfunction
    function logic signed [31:0] lo(input logic [1:0] r);
        return r == `IIC_RNG_BI10 ? `IIC_V10_LO : `IIC_ZERO_LO;
    endfunction
    // fl: 0 plain float, 1 wire off, 2 wire off and block detached, 3 wire off in integer format
    task check_set;
        for (int c = 0; c < 6; c++) begin
            logic signed [31:0] x, e;
            logic cur;
            x = adc[c*32 +: 32];
            cur = rg[c] == `IIC_RNG_MA20 && fl != 2;
            e = fl == 0 ? x : cur ? (fl == 3 ? `IIC_INT_MIN : lo(rg[c])) : (fl == 3 ? `IIC_INT_MAX : hi(rg[c]));
            chk("mc_data", e, i_own.data[c]);
            chk("mc_status", dis[c] ? 32'h0 : {fl ? cur : x < lo(rg[c]), fl ? !cur : x > hi(rg[c]), 5'h0},
                i_own.stat[c]);
        end
    endtask
    initial begin
        void'($urandom(97));
        repeat (8) @(posedge clock);
        rst_n <= 1;
        rd(`IIC_A_CTRL, 32'h3);
        rd(`IIC_A_RTS, 32'h19);
        rd(8'hFF, 32'h0);
        wr(`IIC_A_RTS, 32'h14);
        wr(`IIC_A_RPI, 32'h0);
        for (int i = 0; i < 5; i++) begin
            fl = i < 2 ? 0 : i - 1;
            if (fl == 3)
                wr(`IIC_A_CTRL, 32'h1);
            wo <= fl != 0 ? 6'h3F : 6'h0;
            removable_terminal_block <= fl == 2;
            for (int c = 0; c < 6; c++) begin
                rg[c] = 2'($urandom % 4);
                dis[c] = $urandom % 4 == 0;
                k = $urandom % 4;
                adc[c*32 +: 32] <= k == 0 ? hi(rg[c]) + 1 : k == 1 ? hi(rg[c]) : k == 2 ? lo(rg[c]) : lo(rg[c]) - 1;
                wr(8'(16 * c + 16), {29'h0, dis[c], rg[c]});
            end
            // First set may predate the new setup
            sets(2);
            check_set();
        end
        wr(`IIC_A_IRQ_MASK, 32'h1);
        sets(1);
        #1 chk("irq", 32'h1, irq);
        wr(`IIC_A_IRQ_MASK, 32'h0);
        #1 chk("irq", 32'h0, irq);
        wr(`IIC_A_RTS, 32'h0);
        wr(`IIC_A_RPI, 32'h3);
        sets(3);
        chk("mc_from_scan", 32'h0, i_own.src);
        check_set();
        // Channel 0 in float: HH 0x1000, deadband 0x100, rate trigger 50 per s
        wr(`IIC_A_RPI, 32'h0);
        wr(`IIC_A_CTRL, 32'h3);
        wr(8'h10, 32'h0);
        wr(8'h12, 32'h1000);
        wr(8'h16, 32'h100);
        wr(8'h17, 32'h32);
        wo <= 6'h0;
        wr(`IIC_A_RTS, 32'h14);
        step(32'h1001, 7'h11);
        step(32'hF80, 7'h11);
        step(32'hF81, 7'h01);
        step(32'hE00, 7'h10);
        wr(8'h11, 32'h14);
        step(32'h1000, 7'h10);
        chk("ch0_data", 32'hF00, i_own.data[0]);
        wr(`IIC_A_CTRL, 32'h1);
        step(32'h2000, 7'h00);
        chk("ch0_data", 32'h100, i_own.data[0]);
        wr(`IIC_A_RTS, 32'h0);
        wr(`IIC_A_IRQ_STAT, 32'h7);
        wr(`IIC_A_IRQ_MASK, 32'h7);
        #1 chk("irq", 32'h0, irq);
        summarize();
    end
endmodule // iic_alarm_logic_tb_top
`default_nettype wire

// File: test/iic_owner_model.sv
// Owner controller model: keeps the latest word and status per channel.
// Assumes one word per cycle; a set counts once its last word lands.
`default_nettype none
module iic_owner_model (
    // Multicast stream
    input wire logic        clock,
    input wire logic        mc_valid,
    input wire logic [2:0]  mc_chan,
    input wire logic [31:0] mc_data,
    input wire logic [6:0]  mc_status,
    input wire logic        mc_last,
    input wire logic        mc_from_scan
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] data [6];
    logic [6:0]  stat [6];
    logic        src;
    int          cnt = 0;
    always @(posedge clock) begin
        if (mc_valid) begin
            data[mc_chan] <= mc_data;
            stat[mc_chan] <= mc_status;
            src           <= mc_from_scan;
            cnt           <= cnt + (mc_last ? 1 : 0);
        end
    end
endmodule // iic_owner_model
`default_nettype wire

// File: test/iic_sva.sv
// Checker on the multicast stream and read port of the alarm logic.
// Assumes ce is held high whenever these properties are judged.
`default_nettype none
module iic_sva (
    // Watched ports
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire logic        mc_valid,
    input wire logic [2:0]  mc_chan,
    input wire logic [6:0]  mc_status,
    input wire logic        mc_last,
    input wire logic        mc_from_scan
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence six_words;
        mc_valid [*6] ##1 !mc_valid;
    endsequence
    burst_shape_a: assert property ($rose(mc_valid) |-> mc_chan == 3'h0 ##0 six_words)
        else $error("multicast burst is not six words from channel 0");
    chan_step_a: assert property (mc_valid && !mc_last |=> mc_chan == $past(mc_chan) + 3'h1)
        else $error("channel number did not step by one");
    last_flag_a: assert property (mc_valid |-> mc_last == (mc_chan == 3'h5))
        else $error("last flag not on channel 5");
    src_hold_a: assert property (mc_valid && !mc_last |=> $stable(mc_from_scan))
        else $error("source flag moved inside a burst");
    // The source flag is set one cycle ahead of the first word
    src_change_a: assert property ($changed(mc_from_scan) |=> $rose(mc_valid))
        else $error("source flag changed outside a burst start");
    flag_excl_a: assert property (mc_valid |-> !(mc_status[5] && mc_status[6]))
        else $error("over and under flags set together");
    rd_idle_a: assert property (ce && !rd_en |=> rd_data == 32'h0)
        else $error("read data not zero without a read");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n && ce |=> !mc_valid && rd_data == 32'h0)
        else $error("outputs active after reset");
endmodule // iic_sva
bind iic_alarm_logic iic_sva i_sva (.clock, .rst_n, .ce, .rd_en, .rd_data, .mc_valid, .mc_chan, .mc_status,
    .mc_last, .mc_from_scan);
`default_nettype wire
